// ### pkg/blmc_pkg.sv
// Purpose: shared constants and types for the bus lock / fatal check block
// Assumes: one bus clock, active-low bus pins modelled as open drain
// Notes:   timing counts are in bus clocks
package blmc_pkg;
	// lock sequencer states
	typedef enum logic [1:0] {
		BLMC_IDLE,
		BLMC_LOCKED,
		BLMC_DRAIN
	} blmc_lock_st_t;

	// fatal check pulse length, in bus clocks
	localparam int unsigned FATAL_PULSE_CLKS = 2;
	localparam logic [3:0]  FATAL_CNT_RST    = 4'h0;
	// config bit positions of the fatal check enable word
	localparam int unsigned CFG_EN_BIT       = 0;
	localparam int unsigned CFG_INT_BIT      = 1;
	localparam int unsigned CFG_INIT_BIT     = 2;
	localparam int unsigned CFG_OBS_BIT      = 3;
	localparam int unsigned CFG_W            = 4;
endpackage : blmc_pkg

// ### pkg/blmc_err_if.sv
// Purpose: carries error events from the main block to the pulse driver
// Assumes: single bus clock domain
// Notes:   fire is a one-cycle request
`timescale 1ns/100ps
`default_nettype none
interface blmc_err_if;
	logic fire;   // request a fatal check pulse
	logic active; // pulse being driven
	modport src (output fire, input active);
	modport drv (input fire, output active);
endinterface : blmc_err_if
`default_nettype wire

// ### rtl/blmc_pulse.sv
// Purpose: drives the shared fatal check line for a fixed pulse
// Assumes: fire is synchronous to core_clk
// Notes:   a new fire during a pulse restarts the count
`timescale 1ns/100ps
`default_nettype none
module blmc_pulse (
	input  wire logic core_clk,
	input  wire logic resetn,
	blmc_err_if.drv   err
);
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;

	// reload on request, else count down
	always_comb begin
		nxt_cnt = cnt_ff;
		if (err.fire) begin
			nxt_cnt = 4'(blmc_pkg::FATAL_PULSE_CLKS);
		end else if (cnt_ff != 4'h0) begin
			nxt_cnt = cnt_ff - 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= blmc_pkg::FATAL_CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign err.active = (cnt_ff != 4'h0);

	a_pulse_len: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$rose(err.active) |-> err.active [*2])
		else $error("fatal check pulse shorter than two clocks");
endmodule : blmc_pulse
`default_nettype wire

// ### rtl/blmc_top.sv
// Purpose: lock indication and fatal check signalling for the front bus
// Assumes: bus pins are open drain, output enable high while pulling low
// Notes:   arbitration itself is outside; this block only signals
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module blmc_top (
	input  wire logic                 core_clk,
	input  wire logic                 resetn,
	// lock requests from the core side
	input  wire logic                 lock_start,
	input  wire logic                 lock_last_done,
	output logic                      bus_owned,
	// priority request pin, seen only
	input  wire logic                 priority_owner_req_n,
	output logic                      priority_seen,
	// lock pin
	input  wire logic                 lock_in_n,
	output logic                      lock_out_n,
	output logic                      lock_oe,
	// fatal check pin
	input  wire logic                 fatal_check_err_in_n,
	output logic                      fatal_check_err_out_n,
	output logic                      fatal_check_err_oe,
	output logic                      fatal_seen,
	// error events and configuration
	input  wire logic [blmc_pkg::CFG_W-1:0] fatal_cfg,
	input  wire logic                 int_error,
	input  wire logic                 init_txn_error,
	input  wire logic                 obs_txn_error,
	output logic                      internal_fault_n
);
	blmc_err_if err_bus ();

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage read by second stage only
	// lock pin echo feeds only the checks; the sequencer trusts its own flop
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_ff <= 3'h7;
			sync2_ff <= 3'h7;
		end else begin
			sync1_ff <= {fatal_check_err_in_n, lock_in_n,
				priority_owner_req_n};
			sync2_ff <= sync1_ff;
		end
	end
	assign priority_seen = ~sync2_ff[0];
	assign fatal_seen    = ~sync2_ff[2];

	////////////////////////////////////////////////////////////////////////
	// lock sequencer
	blmc_pkg::blmc_lock_st_t st_ff;
	blmc_pkg::blmc_lock_st_t nxt_st;
	logic                    lock_ff;
	logic                    nxt_lock;

	// lock drops only after the last transaction ends
	always_comb begin
		nxt_st   = st_ff;
		nxt_lock = lock_ff;
		case (st_ff)
			blmc_pkg::BLMC_IDLE: begin
				if (lock_start) begin
					nxt_st   = blmc_pkg::BLMC_LOCKED;
					nxt_lock = 1'b1;
				end
			end
			blmc_pkg::BLMC_LOCKED: begin
				if (lock_last_done) begin
					nxt_st   = blmc_pkg::BLMC_DRAIN;
					nxt_lock = 1'b0;
				end
			end
			blmc_pkg::BLMC_DRAIN: begin
				// one idle clock so the priority agent can see release
				nxt_st = blmc_pkg::BLMC_IDLE;
			end
			default: begin
				nxt_st   = blmc_pkg::BLMC_IDLE;
				nxt_lock = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff   <= blmc_pkg::BLMC_IDLE;
			lock_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			lock_ff <= nxt_lock;
		end
	end

	assign lock_out_n = 1'b0;
	assign lock_oe    = lock_ff;
	// owner keeps bus through lock; priority agent waits on our lock
	assign bus_owned  = lock_ff;

	////////////////////////////////////////////////////////////////////////
	// internal fault latch and fatal check requests
	logic ifault_ff;
	logic nxt_ifault;
	logic fire;

	always_comb begin
		nxt_ifault = ifault_ff | int_error;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ifault_ff <= 1'b0;
		end else begin
			ifault_ff <= nxt_ifault;
		end
	end
	assign internal_fault_n = ~ifault_ff;

	// master enable gates the optional sources; observer always reports
	assign fire = (fatal_cfg[blmc_pkg::CFG_EN_BIT] & (
		(fatal_cfg[blmc_pkg::CFG_INT_BIT] & int_error) |
		(fatal_cfg[blmc_pkg::CFG_INIT_BIT] & init_txn_error))) |
		obs_txn_error;
	assign err_bus.fire = fire;

	blmc_pulse u_pulse (
		.core_clk (core_clk),
		.resetn   (resetn),
		.err      (err_bus.drv)
	);

	assign fatal_check_err_out_n = 1'b0;
	assign fatal_check_err_oe    = err_bus.active;

	////////////////////////////////////////////////////////////////////////
	// checks
	// fatal check pulse as the pin shows it: two clocks low
	sequence s_fatal_pulse;
		fatal_check_err_oe ##1 fatal_check_err_oe;
	endsequence
	// own lock long enough to come back through the sync
	sequence s_lock_run;
		lock_oe [*3];
	endsequence
	// priority request low on two edges in a row
	sequence s_prio_low;
		!priority_owner_req_n ##1 !priority_owner_req_n;
	endsequence

	// lock sequencer and pin synchronisers
	a_lock_hold: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(lock_oe && !lock_last_done) |=> lock_oe)
		else $error("lock dropped before last transaction");
	a_lock_start: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_ff == blmc_pkg::BLMC_IDLE && lock_start) |=> lock_oe)
		else $error("lock not driven after start");
	a_lock_echo: assert property (
		@(posedge core_clk) disable iff (!resetn)
		s_lock_run |-> !sync2_ff[1])
		else $error("own lock not seen back on the pin");
	a_lock_refuse: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_ff == blmc_pkg::BLMC_DRAIN && lock_start)
		|=> !lock_oe)
		else $error("lock restarted without an idle clock");
	a_drain_gap: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$fell(lock_oe) |-> !lock_oe ##1 !lock_oe)
		else $error("lock reasserted without idle clock");
	a_prio_sync: assert property (
		@(posedge core_clk) disable iff (!resetn)
		s_prio_low |=> priority_seen)
		else $error("priority request not passed through the sync");

	// internal fault: sticky, set by any internal error
	a_fault_sticky: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!internal_fault_n |=> !internal_fault_n)
		else $error("internal fault released without reset");
	a_fault_set: assert property (
		@(posedge core_clk) disable iff (!resetn)
		int_error |=> !internal_fault_n)
		else $error("internal fault not raised");

	// fatal check sources and gating
	a_int_fatal: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(int_error && fatal_cfg[blmc_pkg::CFG_EN_BIT]
			&& fatal_cfg[blmc_pkg::CFG_INT_BIT]) |=> s_fatal_pulse)
		else $error("internal error did not drive fatal check");
	a_init_fatal: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(init_txn_error && fatal_cfg[blmc_pkg::CFG_EN_BIT]
			&& fatal_cfg[blmc_pkg::CFG_INIT_BIT]) |=> s_fatal_pulse)
		else $error("initiator error did not drive fatal check");
	a_obs_fatal: assert property (
		@(posedge core_clk) disable iff (!resetn)
		obs_txn_error |=> s_fatal_pulse)
		else $error("observed error did not drive fatal check");
	a_cfg_off: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(!fatal_cfg[blmc_pkg::CFG_EN_BIT] && !obs_txn_error
			&& !fatal_check_err_oe) |=> !fatal_check_err_oe)
		else $error("fatal check driven while disabled");
endmodule : blmc_top
`default_nettype wire

// ### tb/blmc_agent_model.sv
// Purpose: other bus agents, a priority owner and a peer raising fatal check
// Assumes: pins are active-low wired lines resolved by the bench
// Notes:   behavioural, answers on the next bus clock
`timescale 1ns/100ps
`default_nettype none
module blmc_agent_model (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic lock_wire_n,
	input  wire logic want_bus,
	input  wire logic peer_err,
	output logic      priority_owner_req_n,
	output logic      peer_fatal_oe,
	output logic      owns
);
	// request follows want_bus one clock later; never breaks a locked run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			priority_owner_req_n <= 1'b1;
			owns                 <= 1'b0;
			peer_fatal_oe        <= 1'b0;
		end else begin
			priority_owner_req_n <= !want_bus;
			owns <= want_bus && !priority_owner_req_n
				&& lock_wire_n;
			peer_fatal_oe <= peer_err;
		end
	end
endmodule : blmc_agent_model
`default_nettype wire

// ### tb/blmc_top_tb_top.sv
// Purpose: self-checking bench for lock and fatal check signalling
// Assumes: inputs change on the falling edge only
// Notes:   pins resolved here as wired-low lines
`timescale 1ns/100ps
`default_nettype none
module blmc_top_tb_top;
	logic clk = 0, rstn = 0, ls = 0, ld = 0, ie = 0, ine = 0, oe_err = 0;
	logic want = 0, peer = 0;
	logic [3:0] cfg = 4'h0;
	logic req_n, owned, pseen, lock_n, lock_oe, f_n, f_oe, fseen, fault_n;
	logic peer_oe, owns, lock_w, fat_w;
	int n_errors = 0, compares = 0;
	// open-drain resolution of the two shared lines
	assign lock_w = lock_oe ? lock_n : 1'b1;
	assign fat_w  = (f_oe ? f_n : 1'b1) & !peer_oe;
	blmc_top dut (.core_clk(clk), .resetn(rstn), .lock_start(ls),
		.lock_last_done(ld), .bus_owned(owned), .priority_owner_req_n(req_n),
		.priority_seen(pseen), .lock_in_n(lock_w), .lock_out_n(lock_n),
		.lock_oe(lock_oe), .fatal_check_err_in_n(fat_w),
		.fatal_check_err_out_n(f_n), .fatal_check_err_oe(f_oe),
		.fatal_seen(fseen), .fatal_cfg(cfg), .int_error(ie),
		.init_txn_error(ine), .obs_txn_error(oe_err), .internal_fault_n(fault_n));
	blmc_agent_model agent (.core_clk(clk), .resetn(rstn), .lock_wire_n(lock_w),
		.want_bus(want), .peer_err(peer), .priority_owner_req_n(req_n),
		.peer_fatal_oe(peer_oe), .owns(owns));
	initial begin
		forever #12.5 clk = !clk;
	end
	task automatic chk(string nm, logic s, logic e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s exp %b got %b", nm, e, s);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic do_reset;
		rstn = 0;
		repeat (20) @(negedge clk);
		rstn = 1;
		chk("fault_n", fault_n, 1'b1);
		chk("lock_oe", lock_oe, 1'b0);
		chk("f_oe", f_oe, 1'b0);
	endtask : do_reset
	// lock held across refused restart; priority agent kept out
	task automatic t_lock;
		want = 1;
		ls = 1;
		@(negedge clk) ls = 0;
		chk("lock_oe", lock_oe, 1'b1);
		chk("owned", owned, 1'b1);
		chk("lock_n", lock_n, 1'b0);
		repeat (3) @(negedge clk);
		ls = 1;
		@(negedge clk) ls = 0;
		repeat (2) @(negedge clk);
		chk("lock_held", lock_oe, 1'b1);
		chk("pseen", pseen, 1'b1);
		chk("owns", owns, 1'b0);
		ld = 1;
		@(negedge clk) ld = 0;
		chk("lock_rel", lock_oe, 1'b0);
		// a start in the idle clock after release is refused
		ls = 1;
		@(negedge clk) ls = 0;
		chk("drain_refuse", lock_oe, 1'b0);
		@(negedge clk);
		chk("owns_after", owns, 1'b1);
		want = 0;
		$display("t_lock done");
	endtask : t_lock
	// one error source under one config, expecting a 2-clock pulse or none
	task automatic fire(int src, logic [3:0] c, logic exp);
		cfg = c;
		{ie, ine, oe_err} = 3'b001 << src;
		@(negedge clk) {ie, ine, oe_err} = 3'b000;
		chk("pulse1", f_oe, exp);
		chk("f_n", f_n, 1'b0);
		@(negedge clk) chk("pulse2", f_oe, exp);
		@(negedge clk) chk("pulse_end", f_oe, 1'b0);
	endtask : fire
	task automatic t_fatal;
		fire(0, 4'h0, 1'b1);
		fire(1, 4'h5, 1'b1);
		fire(1, 4'h4, 1'b0);
		fire(1, 4'h1, 1'b0);
		chk("fault_clear", fault_n, 1'b1);
		fire(2, 4'h1, 1'b0);
		fire(2, 4'h3, 1'b1);
		chk("fault_low", fault_n, 1'b0);
		// a second error during the pulse restarts its count
		oe_err = 1;
		repeat (2) @(negedge clk);
		oe_err = 0;
		chk("retrig1", f_oe, 1'b1);
		@(negedge clk) chk("retrig2", f_oe, 1'b1);
		@(negedge clk) chk("retrig_end", f_oe, 1'b0);
		repeat (10) @(negedge clk);
		chk("fault_stuck", fault_n, 1'b0);
		$display("t_fatal done");
	endtask : t_fatal
	// a peer pulls the shared line; we only watch
	task automatic t_peer;
		peer = 1;
		repeat (4) @(negedge clk);
		chk("fseen", fseen, 1'b1);
		chk("f_oe_idle", f_oe, 1'b0);
		peer = 0;
		repeat (4) @(negedge clk);
		chk("fseen_off", fseen, 1'b0);
		$display("t_peer done");
	endtask : t_peer
	initial begin
		@(negedge clk);
		do_reset();
		t_lock();
		t_fatal();
		t_peer();
		do_reset();
		close_out();
	end
	// watchdog: the tests take under a hundred clocks
	initial begin
		#(25 * 3000);
		n_errors++;
		close_out();
	end
endmodule : blmc_top_tb_top
`default_nettype wire
